//--- hw/fpec_pkg.sv
// Constants and types shared by the flash program/erase controller.
// Assumes a 250 MHz system clock; timing counts derive from it.
package fpec_pkg;

  localparam logic [7:0]  KEY_CODE_FIRST     = 8'hA5;
  localparam logic [7:0]  KEY_CODE_SECOND    = 8'hF1;
  localparam int          PAGE_BYTES         = 512;
  localparam int          PAGE_OFS_W         = 9;
  localparam logic [7:0]  ERASED_BYTE        = 8'hFF;
  localparam logic [15:0] SHORT_ADDR_MAX     = 16'h00FF;
  localparam logic [7:0]  SFR_ADDR_LEVEL_LOW = 8'h93;
  localparam logic [7:0]  SFR_ADDR_LEVEL_HI  = 8'h94;
  localparam logic [7:0]  SFR_PAGE_MONITOR   = 8'h01;
  localparam logic [7:0]  LEVEL_HI_RESET     = 8'h00;

  // Operation times in ns, cycles derived from the clock period
  localparam int CLK_PERIOD_NS   = 4;
  localparam int PROG_TIME_NS    = 20000;
  localparam int ERASE_TIME_NS   = 20000000;
  localparam int PROG_CYCLES     = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES    = ERASE_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    KEY_LOCKED   = 2'b00,
    KEY_FIRST    = 2'b01,
    KEY_UNLOCKED = 2'b10,
    KEY_BLOCKED  = 2'b11
  } fpec_key_e;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_MERGE = 2'b01,
    SEQ_WAIT  = 2'b10
  } fpec_seq_e;

endpackage : fpec_pkg

//--- hw/fpec_timer.sv
// Down-counter timing one program or erase operation.
// Assumes i_start is a one-cycle pulse while idle.
`timescale 1ns/10ps
`default_nettype none
module fpec_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Control
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_load,
  // Status
  output logic              o_busy,
  output logic              o_done
);

  logic [W-1:0] count_r;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      count_r <= '0;
    end else if (i_start) begin
      count_r <= i_load;
    end else if (count_r != '0) begin
      count_r <= count_r - W'(1);
    end
  end

  assign o_busy = (count_r != '0);
  assign o_done = (count_r == W'(1));

endmodule : fpec_timer
`default_nettype wire

//--- hw/fpec_top.sv
// Flash program/erase controller: unlock, routing, erase, byte and
// two-byte block programming, supply monitor threshold registers.
// Assumes the CPU holds off new writes while o_cpu_stall is high and
// the array presents i_fl_rdata for o_fl_addr combinationally.
`timescale 1ns/10ps
`default_nettype none

module fpec_top #(
  parameter int          TMR_W       = 24,
  parameter int          PROG_CYC    = fpec_pkg::PROG_CYCLES,
  parameter int          ERASE_CYC   = fpec_pkg::ERASE_CYCLES,
  parameter logic [7:0]  LVL_HI_INIT = fpec_pkg::LEVEL_HI_RESET
) (
  // Clock and resets
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_por,
  // Control bits
  input  wire logic        i_store_write_enable,
  input  wire logic        i_store_erase_enable,
  input  wire logic        i_write_timing_enable,
  input  wire logic        i_block_write_enable,
  input  wire logic [1:0]  i_code_bank_select,
  // Key register write
  input  wire logic        i_key_wr,
  input  wire logic [7:0]  i_key_data,
  // External-space byte writes
  input  wire logic        i_xw_valid,
  input  wire logic        i_xw_short,
  input  wire logic [15:0] i_xw_addr,
  input  wire logic [7:0]  i_xw_data,
  output logic             o_xram_wr,
  output logic             o_cpu_stall,
  // Special register port
  input  wire logic        i_sfr_wr,
  input  wire logic [7:0]  i_sfr_page,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic [7:0]       o_sfr_rdata,
  // Supply monitor
  input  wire logic [7:0]  i_level_low_trim,
  input  wire logic        i_mon_sel_wr,
  input  wire logic        i_mon_sel_high,
  input  wire logic        i_regulator_low,
  output logic             o_mon_high,
  output logic [7:0]       o_mon_level_high,
  output logic             o_reset_hold,
  // Flash array
  input  wire logic [15:0] i_fl_rdata,
  output logic             o_fl_prog,
  output logic             o_fl_erase,
  output logic             o_fl_two,
  output logic [17:0]      o_fl_addr,
  output logic [15:0]      o_fl_wdata,
  // Status
  output logic             o_unlocked,
  output logic             o_blocked
);

  fpec_pkg::fpec_seq_e seq_r;

  logic              unlocked;
  logic              blocked;
  logic              tmr_busy;
  logic              tmr_done;
  logic              tmr_start;
  logic [TMR_W-1:0]  tmr_load;
  logic              short_bad;
  logic              attempt;
  logic              accept;
  logic              do_erase;
  logic              cache_hit;
  logic              do_cache;
  logic              do_prog;
  logic              cache_vld_r;
  logic [15:0]       cache_addr_r;
  logic [7:0]        cache_data_r;
  logic [15:0]       new_data_r;
  logic              two_r;
  logic              mon_high_r;
  logic [7:0]        level_hi_r;
  logic              hold_r;

  function automatic logic [17:0] flash_addr(input logic [1:0]  bank,
                                             input logic [15:0] addr);
    flash_addr = {bank, addr};
  endfunction : flash_addr

  // Writes only reach flash from idle; CPU is stalled otherwise
  assign short_bad = i_xw_short && (i_xw_addr > fpec_pkg::SHORT_ADDR_MAX);
  assign attempt   = i_xw_valid && i_store_write_enable && !short_bad &&
                     i_write_timing_enable && (seq_r == fpec_pkg::SEQ_IDLE);
  assign accept    = attempt && unlocked;
  assign do_erase  = accept && i_store_erase_enable;
  assign cache_hit = cache_vld_r && (i_xw_addr == cache_addr_r + 16'h0001);
  assign do_cache  = accept && !i_store_erase_enable && i_block_write_enable && !cache_hit;
  assign do_prog   = accept && !i_store_erase_enable && !do_cache;

  // Route writes to flash while write enable holds
  assign o_xram_wr = i_xw_valid && !i_store_write_enable;

  fpec_unlock u_unlock (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_key_wr   (i_key_wr),
    .i_key_data (i_key_data),
    .i_attempt  (attempt),
    .o_unlocked (unlocked),
    .o_blocked  (blocked)
  );

  assign o_unlocked = unlocked;
  assign o_blocked  = blocked;

  assign tmr_start = o_fl_prog || o_fl_erase;
  assign tmr_load  = o_fl_erase ? TMR_W'(ERASE_CYC) : TMR_W'(PROG_CYC);

  fpec_timer #(
    .W (TMR_W)
  ) u_timer (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_start  (tmr_start),
    .i_load   (tmr_load),
    .o_busy   (tmr_busy),
    .o_done   (tmr_done)
  );

  // Operation sequencer
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      seq_r <= fpec_pkg::SEQ_IDLE;
    end else begin
      case (seq_r)
        fpec_pkg::SEQ_IDLE: begin
          if (do_erase) begin
            seq_r <= fpec_pkg::SEQ_WAIT;
          end else if (do_prog) begin
            seq_r <= fpec_pkg::SEQ_MERGE;
          end
        end
        fpec_pkg::SEQ_MERGE: begin
          seq_r <= fpec_pkg::SEQ_WAIT;
        end
        fpec_pkg::SEQ_WAIT: begin
          if (tmr_done) begin
            seq_r <= fpec_pkg::SEQ_IDLE;
          end
        end
        default: begin
          seq_r <= fpec_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Stall covers the whole operation, including the merge cycle
  assign o_cpu_stall = (seq_r != fpec_pkg::SEQ_IDLE);

  // Array address and new data
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_fl_addr  <= '0;
      new_data_r <= '0;
      two_r      <= 1'b0;
    end else if (do_erase) begin
      o_fl_addr  <= flash_addr(i_code_bank_select,
                               {i_xw_addr[15:fpec_pkg::PAGE_OFS_W],
                                fpec_pkg::PAGE_OFS_W'(0)});
      two_r      <= 1'b0;
    end else if (do_prog && cache_hit) begin
      o_fl_addr  <= flash_addr(i_code_bank_select, cache_addr_r);
      new_data_r <= {i_xw_data, cache_data_r};
      two_r      <= 1'b1;
    end else if (do_prog) begin
      o_fl_addr  <= flash_addr(i_code_bank_select, i_xw_addr);
      new_data_r <= {fpec_pkg::ERASED_BYTE, i_xw_data};
      two_r      <= 1'b0;
    end
  end

  // Merge with current contents so no bit can rise
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_fl_wdata <= '0;
      o_fl_two   <= 1'b0;
    end else if (seq_r == fpec_pkg::SEQ_MERGE) begin
      o_fl_wdata <= new_data_r & (two_r ? i_fl_rdata :
                                  {fpec_pkg::ERASED_BYTE, i_fl_rdata[7:0]});
      o_fl_two   <= two_r;
    end
  end

  // Start pulses to the array
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_fl_prog  <= 1'b0;
      o_fl_erase <= 1'b0;
    end else begin
      o_fl_prog  <= (seq_r == fpec_pkg::SEQ_MERGE);
      o_fl_erase <= do_erase;
    end
  end

  // Block-write cache; lone first bytes are dropped when block write is disabled or replaced by the next uncached byte
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_block_write_enable) begin
      cache_vld_r  <= 1'b0;
      cache_addr_r <= '0;
      cache_data_r <= '0;
    end else if (do_cache) begin
      cache_vld_r  <= 1'b1;
      cache_addr_r <= i_xw_addr;
      cache_data_r <= i_xw_data;
    end else if (accept) begin
      cache_vld_r  <= 1'b0;
    end
  end

  // Monitor threshold select; survives non-power-on resets
  always_ff @(posedge i_clk) begin
    if (i_por) begin
      mon_high_r <= 1'b0;
    end else if (i_mon_sel_wr) begin
      mon_high_r <= i_mon_sel_high;
    end
  end

  // Latch reset hold if high threshold sits above the raw regulator during reset; cleared only by power-on
  always_ff @(posedge i_clk) begin
    if (i_por) begin
      hold_r <= 1'b0;
    end else if (!i_resetn && mon_high_r && i_regulator_low) begin
      hold_r <= 1'b1;
    end
  end

  // High level setting register on monitor page
  always_ff @(posedge i_clk) begin
    if (i_por) begin
      level_hi_r <= LVL_HI_INIT;
    end else if (i_sfr_wr && (i_sfr_page == fpec_pkg::SFR_PAGE_MONITOR) &&
                 (i_sfr_addr == fpec_pkg::SFR_ADDR_LEVEL_HI)) begin
      level_hi_r <= i_sfr_wdata;
    end
  end

  // Read data; unmapped locations read zero
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_sfr_rdata <= '0;
    end else if (i_sfr_page != fpec_pkg::SFR_PAGE_MONITOR) begin
      o_sfr_rdata <= '0;
    end else if (i_sfr_addr == fpec_pkg::SFR_ADDR_LEVEL_LOW) begin
      o_sfr_rdata <= i_level_low_trim;
    end else if (i_sfr_addr == fpec_pkg::SFR_ADDR_LEVEL_HI) begin
      o_sfr_rdata <= level_hi_r;
    end else begin
      o_sfr_rdata <= '0;
    end
  end

  assign o_mon_high       = mon_high_r;
  assign o_mon_level_high = level_hi_r;
  assign o_reset_hold     = hold_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_issue;
    o_fl_prog || o_fl_erase;
  endsequence

  sequence s_hold_stall;
    o_cpu_stall ##1 o_cpu_stall;
  endsequence

  a_stall_on_issue: assert property (s_issue |-> s_hold_stall)
    else $error("CPU not stalled across operation");

  a_timer_stall: assert property (tmr_busy |-> o_cpu_stall)
    else $error("Timer running without stall");

  a_erase_enables: assert property (o_fl_erase |-> $past(i_store_erase_enable)
                                    && $past(i_store_write_enable))
    else $error("Erase without both enables");

  a_erase_aligned: assert property (o_fl_erase |-> o_fl_addr[8:0] == 9'h000)
    else $error("Erase address not page aligned");

  a_prog_clears: assert property (o_fl_prog |->
                   (o_fl_wdata[7:0] & ~$past(i_fl_rdata[7:0])) == 8'h00)
    else $error("Programming would raise a bit");

  // Upper byte only matters when a cached pair is committed
  a_pair_clears: assert property (o_fl_prog && o_fl_two |->
                   (o_fl_wdata[15:8] & ~$past(i_fl_rdata[15:8])) == 8'h00)
    else $error("Pair programming would raise a bit");

  a_short_addr: assert property (i_xw_valid && short_bad |=>
                                 !o_fl_erase && seq_r != fpec_pkg::SEQ_MERGE)
    else $error("Short address write reached flash");

  a_relock_op: assert property (accept |=> !unlocked)
    else $error("Lock not restored after operation");

  a_blocked_sticky: assert property (blocked |=> blocked)
    else $error("Blocked state left without reset");

  a_cache_held: assert property (do_cache |=> !o_fl_prog && !o_cpu_stall)
    else $error("Cached byte committed alone");

  a_route_flash: assert property (i_xw_valid && i_store_write_enable |-> !o_xram_wr)
    else $error("Flash write leaked to data RAM");

  a_pair_commit: assert property (do_prog && cache_hit |=> ##1 o_fl_prog && o_fl_two)
    else $error("Block pair not committed together");

endmodule : fpec_top
`default_nettype wire

//--- hw/fpec_unlock.sv
// Two-code unlock state machine for flash modification.
// Assumes key writes and attempts arrive as one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
module fpec_unlock (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Key register writes
  input  wire logic       i_key_wr,
  input  wire logic [7:0] i_key_data,
  // Flash operation attempt
  input  wire logic       i_attempt,
  // State
  output logic            o_unlocked,
  output logic            o_blocked
);

  fpec_pkg::fpec_key_e state_r;
  fpec_pkg::fpec_key_e state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fpec_pkg::KEY_LOCKED: begin
        if (i_attempt) begin
          state_nxt = fpec_pkg::KEY_BLOCKED;
        end else if (i_key_wr) begin
          state_nxt = (i_key_data == fpec_pkg::KEY_CODE_FIRST) ?
                      fpec_pkg::KEY_FIRST : fpec_pkg::KEY_BLOCKED;
        end
      end
      fpec_pkg::KEY_FIRST: begin
        if (i_attempt) begin
          state_nxt = fpec_pkg::KEY_BLOCKED;
        end else if (i_key_wr) begin
          // Any gap between codes is fine; only order counts
          state_nxt = (i_key_data == fpec_pkg::KEY_CODE_SECOND) ?
                      fpec_pkg::KEY_UNLOCKED : fpec_pkg::KEY_BLOCKED;
        end
      end
      fpec_pkg::KEY_UNLOCKED: begin
        if (i_attempt) begin
          state_nxt = fpec_pkg::KEY_LOCKED;
        end else if (i_key_wr) begin
          state_nxt = fpec_pkg::KEY_BLOCKED;
        end
      end
      default: begin
        state_nxt = fpec_pkg::KEY_BLOCKED;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_r <= fpec_pkg::KEY_LOCKED;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_unlocked = (state_r == fpec_pkg::KEY_UNLOCKED);
  assign o_blocked  = (state_r == fpec_pkg::KEY_BLOCKED);

endmodule : fpec_unlock
`default_nettype wire

//--- verif/fpec_flash_model.sv
// Behavioural flash array facing the controller: four 512-byte pages.
// Assumes address bits above 10, including bank select in bits 17:16, are ignored here.
`timescale 1ns/10ps
`default_nettype none
module fpec_flash_model (
  // Clock
  input  wire logic        i_clk,
  // Commands
  input  wire logic        i_prog,
  input  wire logic        i_erase,
  input  wire logic        i_two,
  input  wire logic [17:0] i_addr,
  input  wire logic [15:0] i_wdata,
  // Read side
  output logic [15:0]      o_rdata
);
  logic [7:0]  mem [0:2047];
  logic [10:0] a;

  assign a = i_addr[10:0];
  assign o_rdata = {mem[a + 11'h001], mem[a]};

  initial begin
    for (int k = 0; k < 2048; k++) mem[k] = 8'hFF;
  end

  always @(posedge i_clk) begin
    if (i_erase) begin
      for (int k = 0; k < 512; k++) mem[{a[10:9], 9'(k)}] = 8'hFF;
    end
    // Cells only discharge, so a program can never raise a bit
    if (i_prog) begin
      mem[a] = mem[a] & i_wdata[7:0];
      if (i_two) mem[a + 11'h001] = mem[a + 11'h001] & i_wdata[15:8];
    end
  end
endmodule : fpec_flash_model
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the flash program/erase controller.
// Assumes short operation counts (4 and 8 cycles) set at the instance.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic i_clk = 0, i_resetn = 0, i_por = 1, we = 0, ee = 0, te = 0, bw = 0;
  logic [1:0] bank = 0;
  logic kwr = 0, xv = 0, xs = 0, swr = 0, msw = 0, msh = 0, rlow = 0;
  logic [7:0] kd = 0, xd = 0, spg = 0, sad = 0, swd = 0;
  logic [15:0] xa = 0, rdata, wdata;
  logic [7:0] srd, lvh;
  logic xram, stall, mhi, hold, prog, ers, two, unl, blk, st;
  logic [17:0] fa, last_addr, last_eaddr;
  logic last_two;
  int fails = 0, n_compared = 0, n_prog = 0, n_erase = 0, cyc = 0, p;

  always #2 i_clk = ~i_clk;

  fpec_top #(.PROG_CYC(4), .ERASE_CYC(8)) uut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_por(i_por),
    .i_store_write_enable(we), .i_store_erase_enable(ee),
    .i_write_timing_enable(te), .i_block_write_enable(bw),
    .i_code_bank_select(bank), .i_key_wr(kwr), .i_key_data(kd),
    .i_xw_valid(xv), .i_xw_short(xs), .i_xw_addr(xa), .i_xw_data(xd),
    .o_xram_wr(xram), .o_cpu_stall(stall), .i_sfr_wr(swr), .i_sfr_page(spg),
    .i_sfr_addr(sad), .i_sfr_wdata(swd), .o_sfr_rdata(srd),
    .i_level_low_trim(8'h6B), .i_mon_sel_wr(msw), .i_mon_sel_high(msh),
    .i_regulator_low(rlow), .o_mon_high(mhi), .o_mon_level_high(lvh),
    .o_reset_hold(hold), .i_fl_rdata(rdata), .o_fl_prog(prog),
    .o_fl_erase(ers), .o_fl_two(two), .o_fl_addr(fa), .o_fl_wdata(wdata),
    .o_unlocked(unl), .o_blocked(blk));

  fpec_flash_model u_fl (.i_clk(i_clk), .i_prog(prog), .i_erase(ers), .i_two(two),
    .i_addr(fa), .i_wdata(wdata), .o_rdata(rdata));

  always @(posedge i_clk) begin
    cyc++;
    if (prog === 1'b1) begin
      n_prog++;
      last_addr = fa;
      last_two = two;
    end
    if (ers === 1'b1) begin
      n_erase++;
      last_eaddr = fa;
    end
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rst();
    @(negedge i_clk);
    i_resetn = 0;
    repeat (20) @(negedge i_clk);
    i_resetn = 1;
  endtask : rst

  task automatic pulse_por();
    @(negedge i_clk);
    i_por = 1;
    @(negedge i_clk);
    i_por = 0;
  endtask : pulse_por

  task automatic key(input logic [7:0] d);
    @(negedge i_clk);
    kwr = 1;
    kd = d;
    @(negedge i_clk);
    kwr = 0;
  endtask : key

  task automatic unlock();
    key(8'hA5);
    key(8'hF1);
  endtask : unlock

  // Stall sampled one cycle after acceptance, then wait it out
  task automatic xw(input logic [15:0] ad, input logic [7:0] d, input logic sh);
    int k;
    @(negedge i_clk);
    xv = 1;
    xa = ad;
    xd = d;
    xs = sh;
    @(negedge i_clk);
    xv = 0;
    xs = 0;
    st = stall;
    for (k = 0; k < 40 && stall !== 1'b0; k++) @(negedge i_clk);
    @(negedge i_clk);
  endtask : xw

  task automatic t_program();
    bank = 2'b10;
    te = 1;
    we = 1;
    key(8'hA5);
    repeat (7) @(negedge i_clk);
    key(8'hF1);
    chk("unlocked", 1, unl);
    p = n_prog;
    xw(16'h0105, 8'h3C, 0);
    chk("stall", 1, st);
    chk("prog count", p + 1, n_prog);
    chk("prog addr", {2'b10, 16'h0105}, last_addr);
    chk("prog two", 0, last_two);
    chk("byte 105", 8'h3C, u_fl.mem[11'h105]);
    chk("relocked", 0, unl);
    unlock();
    xw(16'h0105, 8'hC3, 0);
    chk("byte 105 and", 8'h00, u_fl.mem[11'h105]);
    bank = 2'b00;
    unlock();
    xw(16'h0205, 8'h5A, 0);
  endtask : t_program

  task automatic t_erase();
    ee = 1;
    bank = 2'b01;
    p = n_erase;
    unlock();
    xw(16'h0123, 8'h00, 0);
    ee = 0;
    bank = 2'b00;
    chk("erase stall", 1, st);
    chk("erase addr", 18'h10000, last_eaddr);
    chk("erase count", p + 1, n_erase);
    chk("byte 105", 8'hFF, u_fl.mem[11'h105]);
    chk("byte 000", 8'hFF, u_fl.mem[11'h000]);
    chk("byte 1FF", 8'hFF, u_fl.mem[11'h1FF]);
    chk("byte 205", 8'h5A, u_fl.mem[11'h205]);
  endtask : t_erase

  task automatic t_route();
    we = 0;
    p = n_prog;
    @(negedge i_clk);
    xv = 1;
    xa = 16'h0107;
    #1 chk("xram wr", 1, xram);
    @(negedge i_clk);
    xv = 0;
    @(negedge i_clk);
    chk("no prog", p, n_prog);
    chk("not blocked", 0, blk);
    we = 1;
  endtask : t_route

  task automatic t_filter();
    p = n_prog;
    unlock();
    xw(16'h0180, 8'hAA, 1);
    chk("short high", p, n_prog);
    chk("still unlocked", 1, unl);
    te = 0;
    xw(16'h0106, 8'hAA, 0);
    chk("timing off", p, n_prog);
    te = 1;
    xw(16'h0040, 8'h0F, 1);
    chk("short low", p + 1, n_prog);
    chk("byte 040", 8'h0F, u_fl.mem[11'h040]);
  endtask : t_filter

  task automatic t_block();
    bw = 1;
    p = n_prog;
    unlock();
    xw(16'h0300, 8'h11, 0);
    chk("cached", p, n_prog);
    chk("cache relock", 0, unl);
    chk("byte 300 held", 8'hFF, u_fl.mem[11'h300]);
    unlock();
    xw(16'h0301, 8'h22, 0);
    chk("pair count", p + 1, n_prog);
    chk("pair two", 1, last_two);
    chk("pair addr", 18'h00300, last_addr);
    chk("byte 300", 8'h11, u_fl.mem[11'h300]);
    chk("byte 301", 8'h22, u_fl.mem[11'h301]);
    unlock();
    xw(16'h0310, 8'h33, 0);
    bw = 0;
    @(negedge i_clk);
    bw = 1;
    unlock();
    xw(16'h0311, 8'h44, 0);
    chk("dropped", p + 1, n_prog);
    chk("byte 310", 8'hFF, u_fl.mem[11'h310]);
    bw = 0;
  endtask : t_block

  task automatic t_monitor();
    spg = 8'h01;
    sad = 8'h93;
    repeat (2) @(negedge i_clk);
    chk("level low", 8'h6B, srd);
    swr = 1;
    sad = 8'h94;
    swd = 8'h6B;
    @(negedge i_clk);
    swr = 0;
    repeat (2) @(negedge i_clk);
    chk("level high rd", 8'h6B, srd);
    chk("level high", 8'h6B, lvh);
    spg = 8'h00;
    msw = 1;
    msh = 1;
    @(negedge i_clk);
    msw = 0;
    @(negedge i_clk);
    chk("mon high", 1, mhi);
    rlow = 1;
    rst();
    chk("hold", 1, hold);
    pulse_por();
    rlow = 0;
    @(negedge i_clk);
    chk("hold por", 0, hold);
    chk("mon low", 0, mhi);
    chk("level init", 8'h00, lvh);
  endtask : t_monitor

  task automatic t_lockout();
    p = n_prog;
    key(8'hA5);
    key(8'h5A);
    chk("bad key", 1, blk);
    unlock();
    chk("stuck", 0, unl);
    xw(16'h0400, 8'h00, 0);
    chk("blocked prog", p, n_prog);
    rst();
    chk("reset clears", 0, blk);
    key(8'hF1);
    chk("out of order", 1, blk);
    rst();
    xw(16'h0400, 8'h00, 0);
    chk("early attempt", 1, blk);
    chk("early prog", p, n_prog);
  endtask : t_lockout

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  initial begin
    rst();
    i_por = 0;
    chk("reset mon", 0, mhi);
    chk("reset level", 8'h00, lvh);
    chk("reset stall", 0, stall);
    chk("reset lock", 0, unl);
    t_program();
    t_erase();
    t_route();
    t_filter();
    t_block();
    t_monitor();
    t_lockout();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
